//--- core/param_bank.sv
// servo parameter bank with write lock, basic setup fields and apb access
// Notes on behaviour
// - starred settings act only after power restore
// - lock comes up at 000Ch, groups writable
// - writes to locked groups are rejected
// - 0000h basic only; 000Bh all but i/o
// - 000Ch all; 100Bh/100Ch read-only except lock
// - command style: 0 point table, 1 indexer
// - invalid regenerative option raises parameter fault
// - position system 1 selects absolute detection
// - position system 0 incremental, reset state
// - gear numerator 1 to 16384, reset 1
// - gear denominator 1 to 16384, reset 1
// - gear product or ratio out raises fault
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module param_bank
    import param_bank_pkg::*;
#(
    parameter int               DEPTH       = 16,
    parameter logic [15:0]      REGEN_VALID = 16'h0001
) (
    // clock, reset, enable
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [param_bank_pkg::ADDR_W-1:0] paddr,
    input  wire logic [param_bank_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic [param_bank_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // power restore strobe
    input  wire logic                        powerRestore,
    // settings in force
    output param_bank_pkg::params_t          activeParams,
    output logic                             indexerMode,
    output logic                             absoluteMode,
    // fault and interrupt
    output logic                             paramFault,
    output logic                             irq
);
    import param_bank_pkg::*;

    localparam int MEM_AW = IDX_W + 2;

    typedef struct packed {
        bus_state_t        bus;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
        params_t           stored;
        params_t           active;
        logic              checkPending;
        logic [EVT_W-1:0]  status;
        logic [EVT_W-1:0]  mask;
        logic              fault;
        logic              irq;
        logic              indexer;
        logic              absolute;
    } bank_t;

    localparam params_t PARAMS_RST = '{
        writeLockCode:  LOCK_RST,
        commandStyle:   STYLE_RST,
        regenOption:    REGEN_RST,
        absoluteSelect: POSSYS_RST,
        gearTop:        GEAR_RST,
        gearBottom:     GEAR_RST
    };

    localparam bank_t BANK_RST = '{
        bus:          BUS_IDLE,
        pready:       1'b0,
        pslverr:      1'b0,
        prdata:       '0,
        stored:       PARAMS_RST,
        active:       PARAMS_RST,
        checkPending: 1'b0,
        status:       '0,
        mask:         '0,
        fault:        1'b0,
        irq:          1'b0,
        indexer:      1'b0,
        absolute:     1'b0
    };

    bank_t st;
    bank_t next_st;

    access_t            acc;
    logic [1:0]         grp;
    logic [IDX_W-1:0]   idx;
    logic               inRange;
    logic               isBasicReg;
    logic               isEvtReg;
    logic               isMemGrp;
    logic               readAllowed;
    logic               writeAllowed;
    logic               valueOk;
    logic [PARAM_W-1:0] oldValue;
    logic [PARAM_W-1:0] newValue;
    logic [DATA_W-1:0]  readValue;
    logic               complete;
    logic               memWrEn;
    logic [MEM_AW-1:0]  memAddr;
    logic [PARAM_W-1:0] memRdData;
    logic               gearBad;
    logic               regenBad;
    logic [EVT_W-1:0]   evtSet;

    // merge the two low byte lanes into a 16-bit parameter
    function automatic logic [PARAM_W-1:0] mergeLanes(
        input logic [PARAM_W-1:0] old,
        input logic [DATA_W-1:0]  data,
        input logic [3:0]         strb
    );
        logic [PARAM_W-1:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // permissions follow the lock code now in force
    always_comb begin
        acc = '{readOk: 4'h1, writeOk: 4'h1, lockOnly: 1'b0};
        case (st.active.writeLockCode)
            LOCK_BASIC_ONLY: acc = '{readOk: 4'h1, writeOk: 4'h1, lockOnly: 1'b0};
            LOCK_NO_IO:      acc = '{readOk: 4'h7, writeOk: 4'h7, lockOnly: 1'b0};
            LOCK_ALL:        acc = '{readOk: 4'hf, writeOk: 4'hf, lockOnly: 1'b0};
            LOCK_RO_BASIC:   acc = '{readOk: 4'h1, writeOk: 4'h0, lockOnly: 1'b1};
            LOCK_RO_ALL:     acc = '{readOk: 4'hf, writeOk: 4'h0, lockOnly: 1'b1};
            default:         acc = '{readOk: 4'h1, writeOk: 4'h1, lockOnly: 1'b0};
        endcase
    end

    // address fields of the current request
    assign grp      = paddr[GRP_LSB+1:GRP_LSB];
    assign idx      = paddr[IDX_LSB+IDX_W-1:IDX_LSB];
    assign inRange  = (paddr[ADDR_W-1:GRP_LSB+2] == '0) && (paddr[1:0] == 2'h0);
    assign isMemGrp = inRange && (grp != GRP_BASIC)
                    && (paddr[GRP_LSB-1:IDX_LSB+IDX_W] == '0);
    assign memAddr  = MEM_AW'({grp - 2'h1, idx});

    // basic register decode and stored value
    always_comb begin
        isBasicReg = 1'b1;
        isEvtReg   = 1'b0;
        oldValue   = '0;
        if (!inRange) begin
            isBasicReg = 1'b0;
        end else if (paddr == OFS_LOCK) begin
            oldValue = st.stored.writeLockCode;
        end else if (paddr == OFS_STYLE) begin
            oldValue = st.stored.commandStyle;
        end else if (paddr == OFS_REGEN) begin
            oldValue = st.stored.regenOption;
        end else if (paddr == OFS_POSSYS) begin
            oldValue = st.stored.absoluteSelect;
        end else if (paddr == OFS_TOP) begin
            oldValue = st.stored.gearTop;
        end else if (paddr == OFS_BOTTOM) begin
            oldValue = st.stored.gearBottom;
        end else if (paddr == OFS_STATUS || paddr == OFS_MASK) begin
            isBasicReg = 1'b0;
            isEvtReg   = 1'b1;
        end else begin
            isBasicReg = 1'b0;
        end
    end

    // value written, and its range check
    always_comb begin
        newValue = mergeLanes(oldValue, pwdata, pstrb);
        valueOk  = 1'b1;
        if (paddr == OFS_TOP || paddr == OFS_BOTTOM) begin
            valueOk = (newValue >= GEAR_MIN) && (newValue <= GEAR_MAX);
        end
    end

    // permission of the request against its group
    always_comb begin
        readAllowed  = 1'b0;
        writeAllowed = 1'b0;
        if (isEvtReg) begin
            readAllowed  = 1'b1;
            writeAllowed = 1'b1;
        end else if (isBasicReg) begin
            readAllowed  = acc.readOk[GRP_BASIC];
            writeAllowed = (acc.writeOk[GRP_BASIC] && valueOk)
                         || (acc.lockOnly && paddr == OFS_LOCK);
        end else if (isMemGrp) begin
            readAllowed  = acc.readOk[grp];
            writeAllowed = acc.writeOk[grp];
        end
    end

    // read data; groups hidden by the lock read as zero
    always_comb begin
        readValue = '0;
        if (isEvtReg) begin
            if (paddr == OFS_STATUS) begin
                readValue = DATA_W'(st.status);
            end else begin
                readValue = DATA_W'(st.mask);
            end
        end else if (isBasicReg && readAllowed) begin
            readValue = DATA_W'(oldValue);
        end else if (isMemGrp && readAllowed) begin
            readValue = DATA_W'(memRdData);
        end else begin
            readValue = '0;
        end
    end

    // transfer completes at the edge that sees pready
    assign complete = psel && penable && st.pready && (st.bus == BUS_DONE);
    assign memWrEn  = complete && pwrite && isMemGrp && writeAllowed;

    // fault sources of the settings in force
    assign regenBad = (st.active.regenOption[PARAM_W-1:4] != '0)
                    || !REGEN_VALID[st.active.regenOption[3:0]];

    // events found one cycle after the settings take over
    assign evtSet = st.checkPending ? {gearBad, regenBad} : '0;

    // bus sequence, register writes, power restore and events
    always_comb begin
        next_st = st;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        case (st.bus)
            BUS_IDLE: begin
                if (psel && !penable) begin
                    next_st.bus = BUS_WAIT;
                end
            end
            BUS_WAIT: begin
                next_st.bus     = BUS_DONE;
                next_st.pready  = 1'b1;
                next_st.prdata  = pwrite ? '0 : readValue;
                next_st.pslverr = pwrite ? !writeAllowed
                                         : !(isBasicReg || isEvtReg || isMemGrp);
            end
            BUS_DONE: begin
                next_st.bus = BUS_IDLE;
            end
            default: begin
                next_st.bus = BUS_IDLE;
            end
        endcase

        // register writes take effect only on completion
        if (complete && pwrite && writeAllowed && isBasicReg) begin
            if (paddr == OFS_LOCK) begin
                next_st.stored.writeLockCode = newValue;
            end else if (paddr == OFS_STYLE) begin
                next_st.stored.commandStyle = newValue;
            end else if (paddr == OFS_REGEN) begin
                next_st.stored.regenOption = newValue;
            end else if (paddr == OFS_POSSYS) begin
                next_st.stored.absoluteSelect = newValue;
            end else if (paddr == OFS_TOP) begin
                next_st.stored.gearTop = newValue;
            end else begin
                next_st.stored.gearBottom = newValue;
            end
        end

        // mask write and write-one-to-clear status; a new event wins
        next_st.status = st.status | evtSet;
        if (complete && pwrite && paddr == OFS_MASK && pstrb[0]) begin
            next_st.mask = pwdata[EVT_W-1:0]; // event bits sit in byte lane 0
        end
        if (complete && pwrite && paddr == OFS_STATUS && pstrb[0]) begin
            next_st.status = (st.status & ~pwdata[EVT_W-1:0]) | evtSet;
        end

        // stored settings come into force only at power restore
        next_st.checkPending = 1'b0;
        if (powerRestore) begin
            next_st.active       = st.stored;
            next_st.checkPending = 1'b1;
        end

        // decoded modes and fault level of the settings in force
        next_st.indexer  = (st.active.commandStyle[0] == STYLE_INDEXER);
        next_st.absolute = (st.active.absoluteSelect[0] == POS_ABSOLUTE);
        next_st.fault    = regenBad || gearBad;
        next_st.irq      = |(next_st.status & next_st.mask);
    end

    // state register, frozen while the enable is low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= BANK_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // group memory for gain/filter, extension and i/o words
    param_store #(
        .GROUPS (3),
        .DEPTH  (DEPTH),
        .WIDTH  (PARAM_W),
        .AW     (MEM_AW)
    ) u_store (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .ce     (ce),
        .wrEn   (memWrEn),
        .wrAddr (memAddr),
        .wrData (pwdata[PARAM_W-1:0]),
        .rdAddr (memAddr),
        .rdData (memRdData)
    );

    // gear pair check on the settings in force
    gear_ratio_check u_gear (
        .gearTop    (st.active.gearTop),
        .gearBottom (st.active.gearBottom),
        .gearBad    (gearBad)
    );

    // outputs straight from the state register
    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = st.pslverr;
    assign activeParams = st.active;
    assign indexerMode  = st.indexer;
    assign absoluteMode = st.absolute;
    assign paramFault   = st.fault;
    assign irq          = st.irq;
endmodule
`default_nettype wire

//--- core/param_bank_pkg.sv
// shared constants, codes and carrier types of the parameter bank
package param_bank_pkg;

    // bus and field widths
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int PARAM_W = 16;

    // byte offsets of the basic group and of the event registers
    localparam logic [ADDR_W-1:0] OFS_LOCK    = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STYLE   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_REGEN   = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_POSSYS  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_TOP     = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_BOTTOM  = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 12'h044;

    // address fields: group select and word index inside a group
    localparam int GRP_LSB = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_W   = 4;
    localparam logic [1:0] GRP_BASIC = 2'h0;
    localparam logic [1:0] GRP_GAIN  = 2'h1;
    localparam logic [1:0] GRP_EXT   = 2'h2;
    localparam logic [1:0] GRP_IO    = 2'h3;

    // write lock codes
    localparam logic [PARAM_W-1:0] LOCK_BASIC_ONLY = 16'h0000;
    localparam logic [PARAM_W-1:0] LOCK_NO_IO      = 16'h000b;
    localparam logic [PARAM_W-1:0] LOCK_ALL        = 16'h000c;
    localparam logic [PARAM_W-1:0] LOCK_RO_BASIC   = 16'h100b;
    localparam logic [PARAM_W-1:0] LOCK_RO_ALL     = 16'h100c;

    // reset values
    localparam logic [PARAM_W-1:0] LOCK_RST   = 16'h000c;
    localparam logic [PARAM_W-1:0] STYLE_RST  = 16'h0000;
    localparam logic [PARAM_W-1:0] REGEN_RST  = 16'h0000;
    localparam logic [PARAM_W-1:0] POSSYS_RST = 16'h0000;
    localparam logic [PARAM_W-1:0] GEAR_RST   = 16'h0001;

    // command style and position system codes
    localparam logic STYLE_POINT_TABLE = 1'b0;
    localparam logic STYLE_INDEXER     = 1'b1;
    localparam logic POS_INCREMENTAL   = 1'b0;
    localparam logic POS_ABSOLUTE      = 1'b1;

    // electronic gear limits
    localparam logic [PARAM_W-1:0] GEAR_MIN      = 16'h0001;
    localparam logic [PARAM_W-1:0] GEAR_MAX      = 16'h4000;
    localparam logic [31:0]        GEAR_PROD_MAX = 32'h0001_86a0;
    localparam logic [15:0]        GEAR_RATIO    = 16'h270f;

    // event status bits
    localparam int EVT_W         = 2;
    localparam int EVT_REGEN_BIT = 0;
    localparam int EVT_GEAR_BIT  = 1;

    // power-cycle qualified basic settings
    typedef struct packed {
        logic [PARAM_W-1:0] writeLockCode;
        logic [PARAM_W-1:0] commandStyle;
        logic [PARAM_W-1:0] regenOption;
        logic [PARAM_W-1:0] absoluteSelect;
        logic [PARAM_W-1:0] gearTop;
        logic [PARAM_W-1:0] gearBottom;
    } params_t;

    // per-group reference and write permission
    typedef struct packed {
        logic [3:0] readOk;
        logic [3:0] writeOk;
        logic       lockOnly;
    } access_t;

    // bus answer sequence
    typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_state_t;

endpackage

//--- core/param_store.sv
// word memory for the gain/filter, extension and i/o parameter groups
`timescale 1ns/10ps
`default_nettype none
module param_store #(
    parameter int GROUPS = 3,
    parameter int DEPTH  = 16,
    parameter int WIDTH  = 16,
    parameter int AW     = 6
) (
    // clock, reset, enable
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // write port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    // read port, registered
    input  wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0]   rdData
);
    typedef struct packed {
        logic [GROUPS*DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0]                   rdData;
    } store_t;

    store_t st;
    store_t next_st;

    // write one word, read the addressed word into the output register
    always_comb begin
        next_st = st;
        if (wrEn) begin
            next_st.words[wrAddr] = wrData;
        end
        next_st.rdData = st.words[rdAddr];
    end

    // contents clear at reset, hold while disabled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rdData = st.rdData;
endmodule
`default_nettype wire

//--- core/gear_ratio_check.sv
// range check of the electronic gear pair
`timescale 1ns/10ps
`default_nettype none
module gear_ratio_check
    import param_bank_pkg::*;
(
    // gear pair
    input  wire logic [PARAM_W-1:0] gearTop,
    input  wire logic [PARAM_W-1:0] gearBottom,
    // verdict
    output logic                    gearBad
);
    logic [31:0] product;
    logic [31:0] topLimit;
    logic [31:0] bottomLimit;

    // product and both ratio bounds in 32 bits
    assign product     = 32'(gearTop) * 32'(gearBottom);
    assign topLimit    = 32'(GEAR_RATIO) * 32'(gearBottom);
    assign bottomLimit = 32'(GEAR_RATIO) * 32'(gearTop);

    // bad when a value is zero, product too big or ratio out of range
    assign gearBad = (gearTop == '0) || (gearBottom == '0)
                   || (product > GEAR_PROD_MAX)
                   || (32'(gearTop) > topLimit)
                   || (32'(gearBottom) > bottomLimit);
endmodule
`default_nettype wire

//--- testbench/param_bank_monitor.sv
// port assertions for the parameter bank
`timescale 1ns/10ps
`default_nettype none
module param_bank_monitor
    import param_bank_pkg::*;
#(
    parameter logic [15:0] REGEN_VALID = 16'h0001
) (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rst_n,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic [DATA_W-1:0]       prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // settings and fault
    input wire logic                    powerRestore,
    input wire param_bank_pkg::params_t activeParams,
    input wire logic                    indexerMode,
    input wire logic                    absoluteMode,
    input wire logic                    paramFault
);
    // completed transfer, gear product and regen code check
    logic        done;
    logic [31:0] prod;
    logic        regenBad;
    logic        roLock;
    assign done = psel && penable && pready;
    assign prod = 32'(activeParams.gearTop) * 32'(activeParams.gearBottom);
    assign regenBad = (activeParams.regenOption > 16'h000f) || !REGEN_VALID[activeParams.regenOption[3:0]];
    assign roLock = (activeParams.writeLockCode == LOCK_RO_BASIC) || (activeParams.writeLockCode == LOCK_RO_ALL);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // setup then one access cycle without ready
    sequence setupPh;
        psel && !penable;
    endsequence
    sequence waitPh;
        psel && penable && !pready;
    endsequence

    a_one_wait: assert property (setupPh ##1 waitPh |=> pready) else $error("answer not after one wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_reset_values: assert property ($rose(rst_n) |-> activeParams == {LOCK_RST, STYLE_RST, REGEN_RST,
        POSSYS_RST, GEAR_RST, GEAR_RST}) else $error("bad settings after reset");
    a_hold_active: assert property (!$stable(activeParams) |-> $past(powerRestore) || !$past(rst_n))
        else $error("settings changed without restore");
    a_style_mode: assert property ($changed(activeParams.commandStyle) |=> indexerMode == $past(activeParams.commandStyle[0]))
        else $error("indexer mode wrong");
    a_abs_mode: assert property ($changed(activeParams.absoluteSelect) |=> absoluteMode == $past(activeParams.absoluteSelect[0]))
        else $error("absolute mode wrong");
    a_io_locked: assert property (done && pwrite && paddr[11:8] == 4'h3 && activeParams.writeLockCode != LOCK_ALL |-> pslverr)
        else $error("io write not refused");
    a_ro_locked: assert property (done && pwrite && roLock && paddr != OFS_LOCK && paddr < OFS_STATUS |-> pslverr)
        else $error("write under read-only lock taken");
    a_hidden_zero: assert property (done && !pwrite && paddr[11:6] == 6'h0c && paddr[1:0] == 2'h0
        && activeParams.writeLockCode != LOCK_ALL && activeParams.writeLockCode != LOCK_RO_ALL
        |-> prdata == 32'h0000_0000 && !pslverr) else $error("hidden read not zero");
    a_gear_fault: assert property (prod > GEAR_PROD_MAX |=> paramFault) else $error("gear product fault missing");
    a_regen_fault: assert property (regenBad |=> paramFault) else $error("regen option fault missing");
endmodule
bind param_bank param_bank_monitor #(.REGEN_VALID(REGEN_VALID)) param_bank_monitor_inst (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .powerRestore(powerRestore), .activeParams(activeParams), .indexerMode(indexerMode),
    .absoluteMode(absoluteMode), .paramFault(paramFault));
`default_nettype wire

//--- testbench/param_bank_test.sv
// self-checking bench for the parameter bank
`timescale 1ns/10ps
`default_nettype none
module param_bank_test;
    import param_bank_pkg::*;
    // lock codes with readable and writable group masks
    localparam logic [15:0] CODES [6] = '{LOCK_BASIC_ONLY, LOCK_NO_IO, LOCK_RO_BASIC, LOCK_RO_ALL, 16'h0005, LOCK_ALL};
    localparam logic [3:0]  RDOK [6]  = '{4'h1, 4'h7, 4'h1, 4'hf, 4'h1, 4'hf};
    localparam logic [3:0]  WROK [6]  = '{4'h1, 4'h7, 4'h0, 4'h0, 4'h1, 4'hf};
    localparam logic [11:0] ROFS [6]  = '{OFS_LOCK, OFS_STYLE, OFS_REGEN, OFS_POSSYS, OFS_TOP, OFS_BOTTOM};
    localparam logic [15:0] RVAL [6]  = '{LOCK_RST, STYLE_RST, REGEN_RST, POSSYS_RST, GEAR_RST, GEAR_RST};
    logic              mclk, rst_n, ce, psel, penable, pwrite, powerRestore;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic              pready, pslverr, indexerMode, absoluteMode, paramFault, irq, err;
    params_t           activeParams;
    logic [15:0]       mem [4];
    logic [15:0]       d;
    int                numErrors, comparisons, cycles;

    param_bank param_bank_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .powerRestore(powerRestore), .activeParams(activeParams), .indexerMode(indexerMode),
        .absoluteMode(absoluteMode), .paramFault(paramFault), .irq(irq));

    // clock and hang guard
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // power restore strobe, then let settings and events settle
    task automatic restore;
        @(posedge mclk);
        powerRestore <= 1'b1;
        @(posedge mclk);
        powerRestore <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        powerRestore = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        // reset values and an unmapped address
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ROFS[i], 32'h0);
            chk(rd, {16'h0000, RVAL[i]});
        end
        apb(1'b0, 12'h080, 32'h0);
        chk(32'(err), 32'h1);
        // every lock code against every group
        mem = '{default: 16'h0000};
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, OFS_LOCK, {16'h0000, CODES[c]});
            chk(32'(err), 32'h0);
            restore();
            for (int g = 0; g < 4; g++) begin
                d = 16'(32'h5a00 + c * 4 + g);
                apb(1'b1, {2'b00, g[1:0], 8'h0c}, {16'h0000, d});
                chk(32'(err), 32'(!WROK[c][g]));
                if (WROK[c][g]) mem[g] = d;
                apb(1'b0, {2'b00, g[1:0], 8'h0c}, 32'h0);
                chk(rd, RDOK[c][g] ? {16'h0000, mem[g]} : 32'h0);
            end
        end
        // gear limits, product fault and its event
        apb(1'b1, OFS_TOP, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, OFS_TOP, 32'h4001);
        chk(32'(err), 32'h1);
        apb(1'b1, OFS_TOP, 32'h4000);
        chk(32'(err), 32'h0);
        apb(1'b1, OFS_BOTTOM, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, OFS_BOTTOM, 32'h4001);
        chk(32'(err), 32'h1);
        apb(1'b1, OFS_BOTTOM, 32'h4000);
        chk(32'(err), 32'h0);
        apb(1'b0, OFS_BOTTOM, 32'h0);
        chk(rd, 32'h4000);
        chk(32'(activeParams.gearTop), 32'h1);
        apb(1'b1, OFS_MASK, 32'h3);
        restore();
        chk(32'(paramFault), 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, OFS_TOP, 32'h2710);
        apb(1'b1, OFS_BOTTOM, 32'h1);
        restore();
        chk(32'(paramFault), 32'h1);
        apb(1'b1, OFS_TOP, 32'h6);
        apb(1'b1, OFS_BOTTOM, 32'h4);
        restore();
        chk(32'(paramFault), 32'h0);
        apb(1'b1, OFS_STATUS, 32'h2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(32'(irq), 32'h0);
        // invalid regen option, masked then unmasked
        apb(1'b1, OFS_REGEN, 32'h2);
        apb(1'b1, OFS_MASK, 32'h2);
        restore();
        chk(32'(paramFault), 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h1);
        // command style and position system take effect on restore
        apb(1'b1, OFS_STYLE, 32'h1);
        apb(1'b1, OFS_POSSYS, 32'h1);
        chk(32'({indexerMode, absoluteMode}), 32'h0);
        restore();
        chk(32'({indexerMode, absoluteMode}), 32'h3);
        apb(1'b1, OFS_STYLE, 32'h0);
        apb(1'b1, OFS_POSSYS, 32'h0);
        // enable low: the restore strobe must not reach the settings
        ce <= 1'b0;
        restore();
        chk(32'({indexerMode, absoluteMode}), 32'h3);
        ce <= 1'b1;
        restore();
        chk(32'({indexerMode, absoluteMode}), 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
